// >>> include/ars_pkg.sv
// Package for the axis homing engine: command codes, modes, offsets, states.
// Assumes a single 125 MHz clock domain and a plain strobe register port.
package ars_pkg;

    localparam logic [7:0] ARS_OPCODE_HOMING = 8'h0d;
    localparam logic [1:0] ARS_HC_START = 2'h0;
    localparam logic [1:0] ARS_HC_STOP = 2'h1;
    localparam logic [1:0] ARS_HC_POLL = 2'h2;

    localparam logic [7:0] ARS_MODE_SWAP = 8'h40;
    localparam logic [7:0] ARS_MODE_INVERT = 8'h80;

    // Register indices
    localparam logic [7:0] ARS_REG_CMD = 8'h00;
    localparam logic [7:0] ARS_REG_STATUS = 8'h01;
    localparam logic [7:0] ARS_REG_STOP_EN = 8'h02;
    localparam logic [7:0] ARS_REG_MODE = 8'h03;
    localparam logic [7:0] ARS_REG_SEARCH_VEL = 8'h04;
    localparam logic [7:0] ARS_REG_CAL_VEL = 8'h05;
    localparam logic [7:0] ARS_REG_DISTANCE = 8'h06;
    localparam logic [7:0] ARS_REG_STALL_FILT = 8'h07;
    localparam logic [7:0] ARS_REG_STALL_VEL = 8'h08;
    localparam logic [7:0] ARS_REG_POSITION = 8'h09;
    localparam logic [7:0] ARS_REG_IRQ_STAT = 8'h0a;
    localparam logic [7:0] ARS_REG_IRQ_MASK = 8'h0b;
    localparam logic [7:0] ARS_REG_LOAD = 8'h0c;

    localparam logic [7:0] ARS_RST_MODE = 8'h01;
    localparam logic [31:0] ARS_RST_SEARCH_VEL = 32'h0000_0200;
    localparam logic [31:0] ARS_RST_CAL_VEL = 32'h0000_0020;
    localparam logic [31:0] ARS_RST_STALL_VEL = 32'h0000_0000;

    localparam int ARS_IRQ_DONE = 0;
    localparam int ARS_IRQ_STALL = 1;
    localparam int ARS_IRQ_STOPPED = 2;

    localparam int ARS_STEP_DIV = 1024;

    typedef enum logic [6:0] {
        ARS_IDLE = 7'b0000001,
        ARS_SEEK_FAR = 7'b0000010,
        ARS_SEEK_REF = 7'b0000100,
        ARS_LEAVE = 7'b0001000,
        ARS_OVERRUN = 7'b0010000,
        ARS_REENTER = 7'b0100000,
        ARS_DONE = 7'b1000000
    } ars_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ars_bus_req_type;

    typedef struct packed {
        logic left;
        logic right;
        logic home;
    } ars_switch_type;

endpackage

// >>> logic/ars_axis_homing.sv
// Axis homing engine with stall stop, driving a step/direction pulse stream.
// Assumes switches and stall-load come from pins; registers on a strobe port.
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
module ars_axis_homing
    import ars_pkg::*;
#(
    parameter int POS_W = 32,
    parameter int LOAD_W = 10
) (
    input wire logic clk_i, // 125 MHz clock
    input wire logic sys_rst_i, // Async reset, high
    input wire ars_pkg::ars_bus_req_type bus_i, // Register request
    output logic [31:0] rdata_o, // Read data, cycle after read
    input wire ars_pkg::ars_switch_type sw_i, // Switch pins, high active; home is active low when mode bit 7 is set in home modes 5 to 8
    input wire logic [LOAD_W-1:0] load_i, // Load value, 0 = max load
    output logic step_o, // Step pulse, one cycle
    output logic dir_o, // Direction, 1 = positive
    output logic busy_o, // Homing running
    output logic irq_o // Level interrupt
);
    import ars_pkg::*;

    // ************************************************
    // Input synchronisers
    // ************************************************
    logic [2:0] sw_sync;
    ars_sync #(.WIDTH(3)) u_sync (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .d_i({sw_i.left, sw_i.right, sw_i.home}),
        .q_o(sw_sync)
    );
    logic [LOAD_W-1:0] load_m;
    logic [LOAD_W-1:0] load_s;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            load_m <= '1;
            load_s <= '1;
        end else begin
            load_m <= load_i;
            load_s <= load_m;
        end
    end

    // ************************************************
    // Registers
    // ************************************************
    logic [7:0] mode;
    logic [1:0] stop_en;
    logic [31:0] search_vel;
    logic [31:0] cal_vel;
    logic [31:0] stall_vel;
    logic stall_en;
    logic [POS_W-1:0] distance;
    logic [POS_W-1:0] position;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [2:0] irq_evt;
    ars_state_type state;
    logic stalled;

    wire wr_cmd = bus_i.wr && bus_i.addr == ARS_REG_CMD
        && bus_i.wdata[15:8] == ARS_OPCODE_HOMING;
    wire cmd_start = wr_cmd && bus_i.wdata[1:0] == ARS_HC_START;
    wire cmd_stop = wr_cmd && bus_i.wdata[1:0] == ARS_HC_STOP;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode <= ARS_RST_MODE;
            stop_en <= 2'h0;
            search_vel <= ARS_RST_SEARCH_VEL;
            cal_vel <= ARS_RST_CAL_VEL;
            stall_vel <= ARS_RST_STALL_VEL;
            stall_en <= 1'b0;
            irq_mask <= 3'h0;
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                ARS_REG_MODE: mode <= bus_i.wdata[7:0];
                ARS_REG_STOP_EN: stop_en <= bus_i.wdata[1:0];
                ARS_REG_SEARCH_VEL: search_vel <= bus_i.wdata;
                ARS_REG_CAL_VEL: cal_vel <= bus_i.wdata;
                ARS_REG_STALL_FILT: stall_en <= bus_i.wdata[0];
                ARS_REG_STALL_VEL: stall_vel <= bus_i.wdata;
                ARS_REG_IRQ_MASK: irq_mask <= bus_i.wdata[2:0];
                default: ;
            endcase
        end
    end

    logic [2:0] irq_clr;
    assign irq_clr = (bus_i.wr && bus_i.addr == ARS_REG_IRQ_STAT)
        ? bus_i.wdata[2:0] : 3'h0;
    for (genvar g = 0; g < 3; g++) begin : g_irq
        // Set wins over a write-one clear in the same cycle
        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                irq_stat[g] <= 1'b0;
            end else if (irq_evt[g]) begin
                irq_stat[g] <= 1'b1;
            end else if (irq_clr[g]) begin
                irq_stat[g] <= 1'b0;
            end
        end
    end
    assign irq_o = |(irq_stat & irq_mask);

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                ARS_REG_STATUS: rdata_o <= {29'h0, stalled,
                    state == ARS_DONE, busy_o};
                ARS_REG_STOP_EN: rdata_o <= {30'h0, stop_en};
                ARS_REG_MODE: rdata_o <= {24'h0, mode};
                ARS_REG_SEARCH_VEL: rdata_o <= search_vel;
                ARS_REG_CAL_VEL: rdata_o <= cal_vel;
                ARS_REG_DISTANCE: rdata_o <= 32'(distance);
                ARS_REG_STALL_FILT: rdata_o <= {31'h0, stall_en};
                ARS_REG_STALL_VEL: rdata_o <= stall_vel;
                ARS_REG_POSITION: rdata_o <= 32'(position);
                ARS_REG_IRQ_STAT: rdata_o <= {29'h0, irq_stat};
                ARS_REG_IRQ_MASK: rdata_o <= {29'h0, irq_mask};
                ARS_REG_LOAD: rdata_o <= 32'(load_s);
                default: rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // ************************************************
    // Mode decode
    // ************************************************
    // Auto-stop enables are stored but never consulted here
    logic [3:0] base;
    logic swap;
    logic home_mode;
    logic home_act;
    logic ref_left;
    logic ref_right;
    assign base = mode[3:0];
    assign home_mode = base >= 4'h5 && base <= 4'h8;
    assign swap = !home_mode && mode[6];
    assign ref_left = swap ? sw_sync[1] : sw_sync[2];
    assign ref_right = swap ? sw_sync[2] : sw_sync[1];
    assign home_act = sw_sync[0] ^ (home_mode && mode[7]);

    // Reference switch for the centring phase
    logic ref_hit;
    always_comb begin
        ref_hit = home_mode ? home_act : ref_left;
    end

    // ************************************************
    // Step generator
    // ************************************************
    logic [31:0] vel;
    logic [31:0] accum;
    logic moving;
    logic dir_pos;
    logic step_now;
    assign step_now = moving && accum >= 32'(ARS_STEP_DIV);
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            accum <= 32'h0;
        end else if (!moving) begin
            accum <= 32'h0;
        end else if (step_now) begin
            accum <= accum - 32'(ARS_STEP_DIV) + vel;
        end else begin
            accum <= accum + vel;
        end
    end
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            step_o <= 1'b0;
            dir_o <= 1'b0;
        end else begin
            step_o <= step_now;
            dir_o <= dir_pos;
        end
    end

    // Stall stop only above threshold speed at max load (load reading of 0)
    wire stall_hit = stall_en && moving && vel > stall_vel
        && load_s == '0;

    // ************************************************
    // Homing state machine
    // ************************************************
    logic [POS_W-1:0] edge_a;
    logic [POS_W-1:0] far_pos;
    logic center;
    logic [POS_W-1:0] mid;
    logic [POS_W:0] mid_sum;
    // Sign-extend first: switch points often lie at negative positions
    assign mid_sum = {position[POS_W-1], position}
        + {edge_a[POS_W-1], edge_a};
    assign mid = mid_sum[POS_W:1];
    // Modes 1 and 2 take the switch edge; 3, 4 and home modes centre
    assign center = base == 4'h3 || base == 4'h4 || home_mode;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ARS_IDLE;
            position <= '0;
            edge_a <= '0;
            far_pos <= '0;
            distance <= '0;
            dir_pos <= 1'b0;
            moving <= 1'b0;
            vel <= 32'h0;
            busy_o <= 1'b0;
            stalled <= 1'b0;
            irq_evt <= 3'h0;
        end else begin
            irq_evt <= 3'h0;
            if (step_now) begin
                position <= dir_pos ? position + 1'b1 : position - 1'b1;
            end
            if (cmd_stop || stall_hit) begin
                state <= ARS_IDLE;
                moving <= 1'b0;
                busy_o <= 1'b0;
                stalled <= stall_hit;
                irq_evt[ARS_IRQ_STOPPED] <= cmd_stop;
                irq_evt[ARS_IRQ_STALL] <= stall_hit;
            end else begin
                case (state)
                    ARS_IDLE, ARS_DONE: begin
                        if (cmd_start && base >= 4'h1 && base <= 4'h8) begin
                            busy_o <= 1'b1;
                            stalled <= 1'b0;
                            moving <= 1'b1;
                            vel <= search_vel;
                            if (base == 4'h2 || base == 4'h3) begin
                                state <= ARS_SEEK_FAR;
                                dir_pos <= !swap;
                            end else begin
                                state <= ARS_SEEK_REF;
                                dir_pos <= home_mode ? (base == 4'h6
                                    || base == 4'h7) : swap;
                            end
                        end
                    end
                    ARS_SEEK_FAR: begin
                        if (ref_right) begin
                            far_pos <= position;
                            dir_pos <= swap;
                            state <= ARS_SEEK_REF;
                        end
                    end
                    ARS_SEEK_REF: begin
                        if (ref_hit) begin
                            vel <= cal_vel;
                            dir_pos <= !dir_pos;
                            state <= ARS_LEAVE;
                        end else if (base == 4'h5 && sw_sync[2]
                            && !dir_pos) begin
                            dir_pos <= 1'b1;
                        end else if (base == 4'h6 && sw_sync[1]
                            && dir_pos) begin
                            dir_pos <= 1'b0;
                        end
                    end
                    ARS_LEAVE: begin
                        if (!ref_hit) begin
                            edge_a <= position;
                            if (center) begin
                                dir_pos <= !dir_pos;
                                state <= ARS_OVERRUN;
                            end else begin
                                dir_pos <= !dir_pos;
                                state <= ARS_REENTER;
                            end
                        end
                    end
                    ARS_OVERRUN: begin
                        // Turn back until the switch is hit again at its near edge
                        if (ref_hit) begin
                            state <= ARS_REENTER;
                        end
                    end
                    ARS_REENTER: begin
                        if (center ? !ref_hit : ref_hit) begin
                            // Zero at midpoint of two switching points
                            moving <= 1'b0;
                            // The axis rests at the second point; count
                            // it from the midpoint so that reads as zero
                            position <= position - mid;
                            distance <= $signed(far_pos) > $signed(mid)
                                ? far_pos - mid
                                : mid - far_pos;
                            busy_o <= 1'b0;
                            irq_evt[ARS_IRQ_DONE] <= 1'b1;
                            state <= ARS_DONE;
                        end
                    end
                    default: state <= ARS_IDLE;
                endcase
            end
        end
    end
endmodule // ars_axis_homing

// >>> logic/ars_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ns
module ars_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk_i, // System clock
    input wire logic sys_rst_i, // Async reset, high
    input wire logic [WIDTH-1:0] d_i, // Raw pins
    output logic [WIDTH-1:0] q_o // Synchronised pins
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta <= '0;
            q_o <= '0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // ars_sync

// >>> sim/ars_axis_homing_sva.sv
// Port-level checker for the axis homing engine.
// Assumes one clock and the strobe register port; bound at the foot.
`timescale 1ns/1ns
module ars_axis_homing_sva
    import ars_pkg::*;
#(
    parameter int POS_W = 32,
    parameter int LOAD_W = 10
) (
    input wire logic clk_i, // Clock
    input wire logic sys_rst_i, // Reset, high
    input wire ars_pkg::ars_bus_req_type bus_i, // Register request
    input wire logic [31:0] rdata_o, // Read data
    input wire ars_pkg::ars_switch_type sw_i, // Switch pins
    input wire logic [LOAD_W-1:0] load_i, // Load value
    input wire logic step_o, // Step pulse
    input wire logic dir_o, // Direction
    input wire logic busy_o, // Homing running
    input wire logic irq_o // Interrupt
);
    // ****************
    // Helper logic
    // ****************
    logic [7:0] mode;
    logic cmd_wr;
    logic mode_ok;
    logic exp_dir;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Shadow of the mode register: the first direction depends on it
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode <= ARS_RST_MODE;
        end else if (bus_i.wr && bus_i.addr == ARS_REG_MODE) begin
            mode <= bus_i.wdata[7:0];
        end
    end
    assign cmd_wr = bus_i.wr && bus_i.addr == ARS_REG_CMD;
    assign mode_ok = mode[5:0] >= 6'h01 && mode[5:0] <= 6'h08;
    always_comb begin
        case (mode[5:0])
            6'h01, 6'h04: exp_dir = mode[6];
            6'h02, 6'h03: exp_dir = !mode[6];
            6'h06, 6'h07: exp_dir = 1'b1;
            default: exp_dir = 1'b0;
        endcase
    end
    // ****************
    // Assertions
    // ****************
    sequence s_start;
        cmd_wr && bus_i.wdata[15:8] == ARS_OPCODE_HOMING && mode_ok
            && bus_i.wdata[1:0] == ARS_HC_START;
    endsequence
    property p_start_busy;
        s_start |=> busy_o;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start did not raise busy");
    property p_start_dir;
        s_start ##0 !busy_o |-> ##[1:8] (step_o && dir_o == exp_dir);
    endproperty
    a_start_dir: assert property (p_start_dir)
        else $error("first steps go the wrong way");
    property p_stop;
        cmd_wr && bus_i.wdata[15:8] == ARS_OPCODE_HOMING
            && bus_i.wdata[1:0] == ARS_HC_STOP |=> !busy_o;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop left busy high");
    property p_bad_op;
        cmd_wr && bus_i.wdata[15:8] != ARS_OPCODE_HOMING && !busy_o
            |=> !busy_o;
    endproperty
    a_bad_op: assert property (p_bad_op)
        else $error("foreign opcode started a search");
    property p_rd_idle;
        !bus_i.rd |=> rdata_o == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data without a read");
    property p_status;
        bus_i.rd && bus_i.addr == ARS_REG_STATUS
            |=> rdata_o[0] == $past(busy_o);
    endproperty
    a_status: assert property (p_status)
        else $error("status busy bit wrong");
    property p_idle_step;
        !busy_o [*2] |-> !step_o;
    endproperty
    a_idle_step: assert property (p_idle_step)
        else $error("step while idle");
    property p_reset_out;
        $fell(sys_rst_i) |-> !busy_o && !step_o && !irq_o;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not quiet after reset");
endmodule // ars_axis_homing_sva
bind ars_axis_homing ars_axis_homing_sva #(.POS_W(POS_W), .LOAD_W(LOAD_W))
    i_ars_axis_homing_sva (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .sw_i(sw_i), .load_i(load_i),
    .step_o(step_o), .dir_o(dir_o), .busy_o(busy_o), .irq_o(irq_o));

// >>> sim/ars_axis_homing_test.sv
// Testbench: homing engine driving the stage model, register port by tasks.
// Assumes the checker is bound to the engine by its own file.
`timescale 1ns/1ns
module ars_axis_homing_test;
    import ars_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    ars_bus_req_type bus = '0;
    ars_switch_type sw;
    logic [9:0] load = 10'h3ff;
    logic [31:0] rdata;
    logic step, dir, busy, irq;
    logic home_low = 1'b0;
    int pos;
    int failures = 0;
    int checks_done = 0;
    ars_axis_homing i_ars_axis_homing (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .bus_i(bus), .rdata_o(rdata), .sw_i(sw), .load_i(load),
        .step_o(step), .dir_o(dir), .busy_o(busy), .irq_o(irq));
    ars_axis_model i_ars_axis_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .step_i(step), .dir_i(dir), .home_low_i(home_low), .pos_o(pos),
        .sw_o(sw));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    // ****************
    // Shared tasks
    // ****************
    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus <= '0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus <= '0;
        #1 d = rdata;
        @(posedge clk_i);
    endtask
    task automatic cmd(input logic [1:0] c);
        wr(ARS_REG_CMD, {16'h0, ARS_OPCODE_HOMING, 6'h0, c});
    endtask
    task automatic reset();
        sys_rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_idle(input int n);
        for (int i = 0; i < n && busy !== 1'b0; i++) @(posedge clk_i);
        if (busy !== 1'b0) begin
            failures++;
            $display("[FAIL] %0t search never ended", $time);
            results();
        end
    endtask
    task automatic wait_step();
        for (int i = 0; i < 20 && step !== 1'b1; i++) @(posedge clk_i);
        if (step !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t no step after start", $time);
            results();
        end
    endtask
    // Distance on the circle, so a zero past the wrap still matches
    function automatic logic near(input int v, input int e);
        int x;
        x = (v - e + 640) % 256 - 128;
        return x >= -2 && x <= 2;
    endfunction
    // ****************
    // Scenarios
    // ****************
    task automatic t_regs();
        logic [31:0] d;
        logic [7:0] a [5] = '{ARS_REG_MODE, ARS_REG_SEARCH_VEL,
            ARS_REG_CAL_VEL, ARS_REG_STALL_VEL, 8'hff};
        logic [31:0] e [5] = '{32'(ARS_RST_MODE), ARS_RST_SEARCH_VEL,
            ARS_RST_CAL_VEL, ARS_RST_STALL_VEL, 32'h0};
        for (int k = 0; k < 5; k++) begin
            rd(a[k], d);
            chk(d, e[k]);
        end
        wr(ARS_REG_STATUS, 32'hffff_ffff);
        rd(ARS_REG_STATUS, d);
        chk(d, 32'h0);
        load <= 10'h155;
        repeat (4) @(posedge clk_i);
        rd(ARS_REG_LOAD, d);
        chk(d, 32'h155);
        $display("t_regs done");
    endtask
    task automatic t_modes();
        logic [31:0] d;
        int m [14] = '{1, 65, 2, 66, 3, 67, 4, 68, 5, 6, 7, 8, 133, 135};
        int z [14] = '{-20, 20, -20, 20, -22, 22, -22, 22,
            10, 10, 10, 10, 10, 10};
        int ds [14] = '{0, 0, 40, 40, 42, 42, 0, 0, 0, 0, 0, 0, 0, 0};
        for (int k = 0; k < 14; k++) begin
            home_low <= m[k] > 128;
            reset();
            wr(ARS_REG_STOP_EN, 32'h3);
            wr(ARS_REG_MODE, 32'(m[k]));
            cmd(ARS_HC_START);
            wait_idle(20000);
            rd(ARS_REG_STATUS, d);
            chk(d, 32'h2);
            rd(ARS_REG_POSITION, d);
            chk({31'h0, !$isunknown(d) && near(pos - d, z[k])},
                32'h1);
            if (ds[k] != 0) begin
                rd(ARS_REG_DISTANCE, d);
                chk({31'h0, !$isunknown(d) && near(d, ds[k])},
                    32'h1);
            end
            rd(ARS_REG_IRQ_STAT, d);
            chk(d & 32'h1, 32'h1);
        end
        home_low <= 1'b0;
        $display("t_modes done");
    endtask
    task automatic t_stop_irq();
        logic [31:0] d;
        reset();
        wr(ARS_REG_MODE, 32'h7);
        cmd(ARS_HC_START);
        wait_step();
        cmd(ARS_HC_STOP);
        rd(ARS_REG_STATUS, d);
        chk(d, 32'h0);
        rd(ARS_REG_IRQ_STAT, d);
        chk(d, 32'h4);
        chk({31'h0, irq}, 32'h0);
        wr(ARS_REG_IRQ_MASK, 32'h4);
        chk({31'h0, irq}, 32'h1);
        wr(ARS_REG_IRQ_STAT, 32'h4);
        chk({31'h0, irq}, 32'h0);
        wr(ARS_REG_CMD, 32'h0c00);
        chk({31'h0, busy}, 32'h0);
        wr(ARS_REG_MODE, 32'h0);
        cmd(ARS_HC_START);
        chk({31'h0, busy}, 32'h0);
        $display("t_stop_irq done");
    endtask
    task automatic t_stall();
        logic [31:0] d;
        int n;
        reset();
        load <= 10'h0;
        wr(ARS_REG_STALL_FILT, 32'h1);
        wr(ARS_REG_STALL_VEL, 32'h100);
        wr(ARS_REG_SEARCH_VEL, 32'h100);
        wr(ARS_REG_MODE, 32'h7);
        cmd(ARS_HC_START);
        wait_step();
        @(posedge clk_i);
        for (n = 1; n < 20 && step !== 1'b1; n++) @(posedge clk_i);
        chk(32'(n), 32'h4);
        chk({31'h0, busy}, 32'h1);
        cmd(ARS_HC_STOP);
        load <= 10'h3ff;
        wr(ARS_REG_STALL_VEL, 32'hff);
        cmd(ARS_HC_START);
        wait_step();
        // Load drops only once the axis moves, as in a real stall
        load <= 10'h0;
        wait_idle(50);
        rd(ARS_REG_STATUS, d);
        chk(d, 32'h4);
        rd(ARS_REG_IRQ_STAT, d);
        chk({31'h0, d[1]}, 32'h1);
        load <= 10'h3ff;
        $display("t_stall done");
    endtask
    initial begin
        reset();
        t_regs();
        t_stop_irq();
        t_stall();
        t_modes();
        results();
    end
endmodule // ars_axis_homing_test

// >>> sim/ars_axis_model.sv
// Stage model: a circular slider of 256 microsteps with three switches.
// Assumes one step pulse per cycle at most from the engine.
`timescale 1ns/1ns
module ars_axis_model
    import ars_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic sys_rst_i, // Reset, parks slider at 0
    input wire logic step_i, // Step pulse
    input wire logic dir_i, // Direction, 1 positive
    input wire logic home_low_i, // Home switch wired active low
    output int pos_o, // Slider position, -128..127
    output ars_pkg::ars_switch_type sw_o // Switch pins
);
    // ****************
    // Slider and switches
    // ****************
    // Circular so that modes ignoring the end switches still come home
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pos_o <= 0;
        end else if (step_i) begin
            // Offset keeps the remainder positive when wrapping below -128
            pos_o <= (pos_o + (dir_i ? 129 : 127) + 256) % 256 - 128;
        end
    end
    // End switches are five steps wide so that a centre exists
    always_comb begin
        sw_o.left = pos_o >= -24 && pos_o <= -20;
        sw_o.right = pos_o >= 20 && pos_o <= 24;
        sw_o.home = (pos_o >= 8 && pos_o <= 12) ^ home_low_i;
    end
endmodule // ars_axis_model
